//--- core/rhs_pkg.sv
// Purpose: Shared constants and carrier types of the humidity result, event flag and alert register block
// Assumes: Byte-wide register port driven by the bus protocol engine; one clock domain
// Notes:   Offsets are byte register addresses seen through the auto-incrementing pointer
package rhs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] OFS_TEMP_LO   = 8'h00;
   localparam logic [7:0] OFS_TEMP_HI   = 8'h01;
   localparam logic [7:0] OFS_HUM_LO    = 8'h02;
   localparam logic [7:0] OFS_HUM_HI    = 8'h03;
   localparam logic [7:0] OFS_EVT       = 8'h04;
   localparam logic [7:0] OFS_TEMP_PEAK = 8'h05;
   localparam logic [7:0] OFS_HUM_PEAK  = 8'h06;
   localparam logic [7:0] OFS_MASK      = 8'h07;
   localparam logic [7:0] PTR_STEP      = 8'h01;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_HUM      = 16'h0000;
   localparam logic [4:0]  RST_FLAGS    = 5'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Flag field layout: status and mask share bits 7..3, bits 2..0 reserved
   localparam int         FLAG_W        = 5;
   localparam int         FLAG_LSB      = 3;
   localparam int         FLAG_MSB      = 7;
   localparam logic [2:0] RSVD_ZERO     = 3'h0;
   localparam int         EVT_DRDY      = 4;
   localparam int         EVT_TH        = 3;
   localparam int         EVT_TL        = 2;
   localparam int         EVT_HH        = 1;
   localparam int         EVT_HL        = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic        temp_valid;
      logic        hum_valid;
      logic [15:0] temp_code;
      logic [15:0] hum_code;
   } rhs_conv_s;

   typedef struct packed {
      logic [7:0] temp_low;
      logic [7:0] temp_high;
      logic [7:0] rh_low;
      logic [7:0] rh_high;
   } rhs_thr_s;

   typedef struct packed {
      logic soft_reset;
      logic alert_pin_global_enable;
      logic int_pol;
      logic int_mode;
      logic oneshot_mode;
   } rhs_cfg_s;

endpackage : rhs_pkg

//--- core/rhs_peak_track.sv
// Purpose: Eight-bit peak detector holding the largest sample seen since reset
// Assumes: Synchronous active-low reset; clr acts as a software reset
// Notes:   Updates only while enabled and only on a strictly higher sample
`timescale 1ns/1ns
module rhs_peak_track (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       clr,
   input  wire logic       enable,
   input  wire logic       sample_valid,
   input  wire logic [7:0] sample,
   output logic      [7:0] peak
);

   logic [7:0] peak_r;
   logic [7:0] peak_nxt;

   always_comb begin
      peak_nxt = peak_r;
      if (enable && sample_valid && (sample > peak_r)) begin
         peak_nxt = sample;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || clr) begin
         peak_r <= rhs_pkg::RST_BYTE;
      end else begin
         peak_r <= peak_nxt;
      end
   end

   assign peak = peak_r;

   chk_peak_never_falls : assert property (@(posedge clk) disable iff (!resetn || clr)
      1'b1 |=> peak_r >= $past(peak_r))
      else $error("Peak value decreased");

   chk_peak_takes_higher : assert property (@(posedge clk) disable iff (!resetn || clr)
      enable && sample_valid && (sample > peak_r) |=> peak_r == $past(sample))
      else $error("Peak did not take higher sample");

   chk_peak_idle_hold : assert property (@(posedge clk) disable iff (!resetn || clr)
      !enable |=> $stable(peak_r))
      else $error("Peak changed while disabled");

endmodule : rhs_peak_track

//--- core/rhs_result_regs.sv
// Purpose: Humidity result, event flags, peak values and alert mask behind the byte register port
// Assumes: Byte port strobes come from the bus protocol engine; conversion results arrive as one-cycle pulses
// Notes:   Read data appears one cycle after the read strobe; pointer advances on every data byte
`timescale 1ns/1ns
module rhs_result_regs (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire rhs_pkg::rhs_conv_s  conv,
   input  wire rhs_pkg::rhs_thr_s   thr,
   input  wire rhs_pkg::rhs_cfg_s   cfg,
   input  wire logic                ptr_load,
   input  wire logic [7:0]          ptr_data,
   output logic                     ptr_hit,
   input  wire logic                rd_stb,
   output logic                     rd_valid,
   output logic      [7:0]          rd_data,
   input  wire logic                wr_stb,
   input  wire logic [7:0]          wr_data,
   output logic                     wr_ack,
   output logic                     alert_pin
);

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode helpers
   function automatic logic is_result_ofs(input logic [7:0] a);
      return (a == rhs_pkg::OFS_TEMP_LO) || (a == rhs_pkg::OFS_TEMP_HI) ||
             (a == rhs_pkg::OFS_HUM_LO)  || (a == rhs_pkg::OFS_HUM_HI);
   endfunction : is_result_ofs

   function automatic logic is_own_ofs(input logic [7:0] a);
      return is_result_ofs(a) || (a == rhs_pkg::OFS_EVT) || (a == rhs_pkg::OFS_TEMP_PEAK) ||
             (a == rhs_pkg::OFS_HUM_PEAK) || (a == rhs_pkg::OFS_MASK);
   endfunction : is_own_ofs

   logic                      srst;
   logic [7:0]                ptr_r;
   logic [7:0]                ptr_nxt;
   logic [15:0]               hum_r;
   logic [15:0]               hum_nxt;
   logic [rhs_pkg::FLAG_W-1:0] evt_r;
   logic [rhs_pkg::FLAG_W-1:0] evt_nxt;
   logic [rhs_pkg::FLAG_W-1:0] mask_r;
   logic [rhs_pkg::FLAG_W-1:0] mask_nxt;
   logic [rhs_pkg::FLAG_W-1:0] upd;
   logic [rhs_pkg::FLAG_W-1:0] cond;
   logic [rhs_pkg::FLAG_W-1:0] clr;
   logic [7:0]                rd_data_r;
   logic [7:0]                rd_data_nxt;
   logic                      rd_valid_r;
   logic                      alert_r;
   logic                      alert_nxt;
   logic                      src_any;
   logic [7:0]                temp_peak;
   logic [7:0]                hum_peak;
   logic                      rd_evt;
   logic                      mask_wr;

   assign srst    = !resetn || cfg.soft_reset;
   assign ptr_hit = is_own_ofs(ptr_data);
   assign rd_evt  = rd_stb && (ptr_r == rhs_pkg::OFS_EVT);
   assign mask_wr = wr_stb && (ptr_r == rhs_pkg::OFS_MASK);
   assign wr_ack  = mask_wr;

   ////////////////////////////////////////////////////////////////////////////////
   // Register pointer
   always_comb begin
      ptr_nxt = ptr_r;
      if (ptr_load) begin
         ptr_nxt = ptr_data;
      end else if (rd_stb || wr_stb) begin
         ptr_nxt = 8'(ptr_r + rhs_pkg::PTR_STEP);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ptr_r <= rhs_pkg::RST_BYTE;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Humidity result
   always_comb begin
      hum_nxt = hum_r;
      if (conv.hum_valid) begin
         hum_nxt = conv.hum_code;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hum_r <= rhs_pkg::RST_HUM;
      end else begin
         hum_r <= hum_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event flags
   always_comb begin
      upd                    = '0;
      cond                   = '0;
      clr                    = '0;
      evt_nxt                = evt_r;
      upd[rhs_pkg::EVT_DRDY] = conv.temp_valid || conv.hum_valid;
      cond[rhs_pkg::EVT_DRDY] = 1'b1;
      upd[rhs_pkg::EVT_TH]   = conv.temp_valid;
      upd[rhs_pkg::EVT_TL]   = conv.temp_valid;
      upd[rhs_pkg::EVT_HH]   = conv.hum_valid;
      upd[rhs_pkg::EVT_HL]   = conv.hum_valid;
      cond[rhs_pkg::EVT_TH]  = conv.temp_code[15:8] > thr.temp_high;
      cond[rhs_pkg::EVT_TL]  = conv.temp_code[15:8] < thr.temp_low;
      cond[rhs_pkg::EVT_HH]  = conv.hum_code[15:8] > thr.rh_high;
      cond[rhs_pkg::EVT_HL]  = conv.hum_code[15:8] < thr.rh_low;
      if (rd_evt) begin
         clr = '1;
      end
      if (rd_stb && is_result_ofs(ptr_r)) begin
         clr[rhs_pkg::EVT_DRDY] = 1'b1;
      end
      for (int i = 0; i < rhs_pkg::FLAG_W; i++) begin
         if (cfg.int_mode && (i != rhs_pkg::EVT_DRDY) && upd[i]) begin
            evt_nxt[i] = cond[i];
         end else begin
            evt_nxt[i] = (evt_r[i] && !clr[i]) || (upd[i] && cond[i]);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         evt_r <= rhs_pkg::RST_FLAGS;
      end else begin
         evt_r <= evt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alert mask
   always_comb begin
      mask_nxt = mask_r;
      if (mask_wr) begin
         mask_nxt = wr_data[rhs_pkg::FLAG_MSB:rhs_pkg::FLAG_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mask_r <= rhs_pkg::RST_FLAGS;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Peak detectors, one-shot mode only
   rhs_peak_track u_temp_peak (
      .clk          (clk),
      .resetn       (resetn),
      .clr          (cfg.soft_reset),
      .enable       (cfg.oneshot_mode),
      .sample_valid (conv.temp_valid),
      .sample       (conv.temp_code[15:8]),
      .peak         (temp_peak)
   );

   rhs_peak_track u_hum_peak (
      .clk          (clk),
      .resetn       (resetn),
      .clr          (cfg.soft_reset),
      .enable       (cfg.oneshot_mode),
      .sample_valid (conv.hum_valid),
      .sample       (conv.hum_code[15:8]),
      .peak         (hum_peak)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read data
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_stb) begin
         unique case (ptr_r)
            rhs_pkg::OFS_HUM_LO:    rd_data_nxt = hum_r[7:0];
            rhs_pkg::OFS_HUM_HI:    rd_data_nxt = hum_r[15:8];
            rhs_pkg::OFS_EVT:       rd_data_nxt = {evt_r, rhs_pkg::RSVD_ZERO};
            rhs_pkg::OFS_TEMP_PEAK: rd_data_nxt = temp_peak;
            rhs_pkg::OFS_HUM_PEAK:  rd_data_nxt = hum_peak;
            rhs_pkg::OFS_MASK:      rd_data_nxt = {mask_r, rhs_pkg::RSVD_ZERO};
            default:                rd_data_nxt = rhs_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data_r  <= rhs_pkg::RST_BYTE;
         rd_valid_r <= 1'b0;
      end else begin
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_stb;
      end
   end

   assign rd_data  = rd_data_r;
   assign rd_valid = rd_valid_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Alert pin
   always_comb begin
      src_any   = cfg.alert_pin_global_enable && |(evt_r & mask_r);
      alert_nxt = cfg.int_pol ? src_any : !src_any;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         alert_r <= 1'b1;
      end else begin
         alert_r <= alert_nxt;
      end
   end

   assign alert_pin = alert_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_drdy_sets : assert property (@(posedge clk) disable iff (srst)
      conv.hum_valid |=> evt_r[rhs_pkg::EVT_DRDY] && hum_r == $past(conv.hum_code))
      else $error("Data-ready or humidity not captured");

   chk_drdy_result_clr : assert property (@(posedge clk) disable iff (srst)
      rd_stb && is_result_ofs(ptr_r) && !conv.temp_valid && !conv.hum_valid |=> !evt_r[rhs_pkg::EVT_DRDY])
      else $error("Data-ready not cleared by result read");

   chk_status_rd_clr : assert property (@(posedge clk) disable iff (srst)
      rd_evt && !conv.temp_valid && !conv.hum_valid |=> evt_r == rhs_pkg::RST_FLAGS)
      else $error("Flags not cleared by status read");

   chk_temp_high_flag : assert property (@(posedge clk) disable iff (srst)
      conv.temp_valid && (conv.temp_code[15:8] > thr.temp_high) |=> evt_r[rhs_pkg::EVT_TH])
      else $error("Temperature high flag missed");

   chk_rh_low_flag : assert property (@(posedge clk) disable iff (srst)
      conv.hum_valid && (conv.hum_code[15:8] < thr.rh_low) |=> evt_r[rhs_pkg::EVT_HL])
      else $error("Humidity low flag missed");

   chk_ptr_advance : assert property (@(posedge clk) disable iff (srst)
      (rd_stb || wr_stb) && !ptr_load |=> ptr_r == 8'($past(ptr_r) + rhs_pkg::PTR_STEP))
      else $error("Pointer did not advance");

   chk_ro_refused : assert property (@(posedge clk) disable iff (srst)
      wr_stb && (ptr_r != rhs_pkg::OFS_MASK) |-> !wr_ack ##1 $stable(mask_r))
      else $error("Read-only write accepted");

   chk_status_rsvd : assert property (@(posedge clk) disable iff (srst)
      rd_stb |=> rd_valid && ((rd_data[2:0] == rhs_pkg::RSVD_ZERO) ||
                 (($past(ptr_r) != rhs_pkg::OFS_EVT) && ($past(ptr_r) != rhs_pkg::OFS_MASK))))
      else $error("Reserved bits not zero");

   chk_alert_gated : assert property (@(posedge clk) disable iff (srst)
      !cfg.alert_pin_global_enable ##1 !$past(srst) |-> alert_pin == !$past(cfg.int_pol))
      else $error("Alert active while globally disabled");

   chk_alert_src : assert property (@(posedge clk) disable iff (srst)
      cfg.alert_pin_global_enable && cfg.int_pol && (evt_r & mask_r) != '0 |=> alert_pin)
      else $error("Enabled source did not raise alert");

   cov_status_read : cover property (@(posedge clk) disable iff (srst)
      evt_r != '0 ##1 rd_evt);

   cov_alert_high : cover property (@(posedge clk) disable iff (srst)
      cfg.int_pol && alert_pin);

   cov_burst_read : cover property (@(posedge clk) disable iff (srst)
      rd_stb ##1 rd_stb ##1 rd_stb);

   cov_mask_write : cover property (@(posedge clk) disable iff (srst)
      mask_wr && wr_data != rhs_pkg::RST_BYTE);

endmodule : rhs_result_regs

//--- tb/rhs_host_model.sv
// Purpose: Host side of the byte register port, as the bus protocol engine presents it
// Assumes: Requests change just after the falling edge and are taken at the next rising edge
// Notes:   Released data lines carry the inverse of the last value
`timescale 1ns/1ns
module rhs_host_model (
   input  wire logic       clk,
   output logic            ptr_load,
   output logic      [7:0] ptr_data,
   input  wire logic       ptr_hit,
   output logic            rd_stb,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output logic            wr_stb,
   output logic      [7:0] wr_data,
   input  wire logic       wr_ack
);
   initial begin
      ptr_load = 1'b0;
      ptr_data = 8'h00;
      rd_stb   = 1'b0;
      wr_stb   = 1'b0;
      wr_data  = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pointer load, then one byte per strobe; the pointer steps on its own
   task automatic set_ptr(input logic [7:0] p, output logic hit);
      @(negedge clk);
      ptr_load = 1'b1;
      ptr_data = p;
      #1 hit = ptr_hit;
      @(negedge clk);
      ptr_load = 1'b0;
      ptr_data = ~p;
   endtask : set_ptr

   task automatic rd_byte(input int gap, output logic [7:0] d, output logic v);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      v = rd_valid;
      d = rd_data;
   endtask : rd_byte

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      @(negedge clk);
      wr_stb  = 1'b1;
      wr_data = d;
      #1 ack = wr_ack;
      @(negedge clk);
      wr_stb  = 1'b0;
      wr_data = ~d;
   endtask : wr_byte

endmodule : rhs_host_model

//--- tb/rhs_result_regs_tb_top.sv
// Purpose: Self-checking bench of the result, event flag and alert register block
// Assumes: Latched or comparator flags; conversions and reads never share a cycle
// Notes:   Reference model kept in plain variables, compared at every result
`timescale 1ns/1ns
module rhs_result_regs_tb_top;
   logic               clk;
   logic               resetn;
   rhs_pkg::rhs_conv_s conv;
   rhs_pkg::rhs_thr_s  thr;
   rhs_pkg::rhs_cfg_s  cfg;
   logic               ptr_load, ptr_hit, rd_stb, rd_valid, wr_stb, wr_ack, alert_pin;
   logic         [7:0] ptr_data, rd_data, wr_data, d, w, th, hh;
   logic        [15:0] hum_m;
   logic         [4:0] fl_m, msk_m;
   logic         [7:0] tpk_m, hpk_m;
   logic               v, a;
   int                 fails, n_compared, cycles, seed, s;

   rhs_result_regs dut (.clk(clk), .resetn(resetn), .conv(conv), .thr(thr), .cfg(cfg), .ptr_load(ptr_load),
      .ptr_data(ptr_data), .ptr_hit(ptr_hit), .rd_stb(rd_stb), .rd_valid(rd_valid), .rd_data(rd_data),
      .wr_stb(wr_stb), .wr_data(wr_data), .wr_ack(wr_ack), .alert_pin(alert_pin));
   rhs_host_model host (.clk(clk), .ptr_load(ptr_load), .ptr_data(ptr_data), .ptr_hit(ptr_hit),
      .rd_stb(rd_stb), .rd_valid(rd_valid), .rd_data(rd_data), .wr_stb(wr_stb), .wr_data(wr_data),
      .wr_ack(wr_ack));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reporting
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp8

   task automatic cmp1(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp1

   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         fails++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reference model
   task automatic mreset();
      hum_m = 16'h0000;
      fl_m  = 5'h00;
      msk_m = 5'h00;
      tpk_m = 8'h00;
      hpk_m = 8'h00;
   endtask : mreset

   function automatic logic [7:0] mbyte(input logic [7:0] o);
      case (o)
         8'h02:   return hum_m[7:0];
         8'h03:   return hum_m[15:8];
         8'h04:   return {fl_m, 3'h0};
         8'h05:   return tpk_m;
         8'h06:   return hpk_m;
         8'h07:   return {msk_m, 3'h0};
         default: return 8'h00;
      endcase
   endfunction : mbyte

   task automatic rd_run(input logic [7:0] st, input int n);
      host.set_ptr(st, a);
      cmp1("ptr_hit", st < 8'h08, a);
      for (int i = 0; i < n; i++) begin
         host.rd_byte(i % 3, d, v);
         cmp1("rd_valid", 1'b1, v);
         cmp8("rd_data", mbyte(st + 8'(i)), d);
         if (st + i <= 3) fl_m[4] = 1'b0;
         if (st + i == 4) fl_m = 5'h00;
      end
   endtask : rd_run

   task automatic conv_pulse(input logic tv, input logic hv);
      @(negedge clk);
      conv = {tv, hv, 16'($random(seed)), 16'($random(seed))};
      th = conv.temp_code[15:8];
      hh = conv.hum_code[15:8];
      if (tv || hv) fl_m[4] = 1'b1;
      if (tv) begin
         fl_m[3] = (th > thr.temp_high) | (fl_m[3] & !cfg.int_mode);
         fl_m[2] = (th < thr.temp_low) | (fl_m[2] & !cfg.int_mode);
         if (cfg.oneshot_mode && th > tpk_m) tpk_m = th;
      end
      if (hv) begin
         hum_m   = conv.hum_code;
         fl_m[1] = (hh > thr.rh_high) | (fl_m[1] & !cfg.int_mode);
         fl_m[0] = (hh < thr.rh_low) | (fl_m[0] & !cfg.int_mode);
         if (cfg.oneshot_mode && hh > hpk_m) hpk_m = hh;
      end
      @(negedge clk);
      conv = {2'b00, ~conv.temp_code, ~conv.hum_code};
   endtask : conv_pulse

   task automatic check_alert();
      logic act;
      repeat (3) @(negedge clk);
      act = cfg.alert_pin_global_enable & (|(fl_m & msk_m));
      cmp1("alert_pin", cfg.int_pol ? act : !act, alert_pin);
   endtask : check_alert

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed       = 85941;
      fails      = 0;
      n_compared = 0;
      cycles     = 0;
      conv       = '0;
      thr        = '0;
      cfg        = '0;
      cfg.int_pol = 1'b1;
      resetn     = 1'b0;
      mreset();
      repeat (4) @(negedge clk);
      cmp1("alert_rst", 1'b1, alert_pin);
      resetn = 1'b1;
      check_alert();
      rd_run(8'h00, 8);
      host.set_ptr(rhs_pkg::OFS_MASK, a);
      host.wr_byte(8'hff, a);
      cmp1("wr_ack", 1'b1, a);
      msk_m = 5'h1f;
      for (int o = 2; o < 7; o++) begin
         host.set_ptr(8'(o), a);
         host.wr_byte(8'($random(seed)), a);
         cmp1("wr_ack", 1'b0, a);
      end
      host.wr_byte(8'hff, a);
      cmp1("wr_ack", 1'b1, a);
      rd_run(8'h02, 6);
      for (int it = 0; it < 80; it++) begin
         @(negedge clk);
         thr = 32'($random(seed));
         cfg = rhs_pkg::rhs_cfg_s'({1'b0, 4'($random(seed))});
         if (it % 4 == 0) begin
            w = 8'($random(seed));
            host.set_ptr(rhs_pkg::OFS_MASK, a);
            host.wr_byte(w, a);
            cmp1("wr_ack", 1'b1, a);
            msk_m = w[7:3];
         end
         conv_pulse(1'($random(seed)), 1'($random(seed)));
         check_alert();
         if ($random(seed) % 2 == 0) begin
            s = $unsigned($random(seed)) % 5;
            rd_run(8'(s), 8 - s);
            check_alert();
         end
      end
      @(negedge clk);
      cfg.soft_reset = 1'b1;
      @(negedge clk);
      cfg.soft_reset = 1'b0;
      mreset();
      rd_run(8'h02, 6);
      rd_run(8'($random(seed)) | 8'h08, 1);
      finish_test();
   end

endmodule : rhs_result_regs_tb_top
